/* File: rtl/tgc_pkg.sv */
// Shared constants for the timer group start/stop and interrupt clear block
package tgc_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_TIMERS = 8;
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 16;
  localparam int HALF_W     = 8;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [15:0] MODE_BASE     = 16'hf320;
  localparam logic [15:0] IRQ_STAT_BASE = 16'hf330;
  localparam logic [15:0] IRQ_CLR_BASE  = 16'hf340;
  localparam logic [15:0] START_OFFS    = 16'hf350;
  localparam logic [15:0] STOP_OFFS     = 16'hf352;
  localparam logic [15:0] RUN_STAT_OFFS = 16'hf354;
  localparam logic [15:0] EVT_STAT_OFFS = 16'hf360;
  localparam logic [15:0] EVT_MASK_OFFS = 16'hf362;

  // ==========================================================
  // Field positions
  localparam int MODE_CS_BIT    = 0;
  localparam int MODE_SPLIT_BIT = 8;
  localparam int MODE_OST_BIT   = 9;
  localparam int MODE_NEG_BIT   = 10;
  localparam int IC_LOWER_BIT   = 0;
  localparam int IC_UPPER_BIT   = 1;
  localparam int IC_RETRIG_BIT  = 7;

  // ==========================================================
  // Masks and reset values
  localparam logic [15:0] MODE_WR_MASK = 16'h077d;
  localparam logic [15:0] MODE_RESET   = 16'h0000;
  localparam logic [15:0] READ_ZERO    = 16'h0000;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
endpackage

/* File: rtl/tgc_channel.sv */
// One timer's run control, split-mode interrupt status and output level
`timescale 1ns/100ps
module tgc_channel (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic splitMode,
  input  wire logic polarityNeg,
  input  wire logic timerTick,
  input  wire logic startLower,
  input  wire logic startUpper,
  input  wire logic stopLower,
  input  wire logic stopUpper,
  input  wire logic matchLower,
  input  wire logic matchUpper,
  input  wire logic clearLower,
  input  wire logic clearUpper,
  input  wire logic retrigger,
  output logic      lowerRun,
  output logic      upperRun,
  output logic      lowerPending,
  output logic      upperPending,
  output logic      irqReq,
  output logic      outLevel
);
  // ==========================================================
  // State
  typedef struct packed {
    logic runLo;
    logic runHi;
    logic stopLo;
    logic stopHi;
    logic pendLo;
    logic pendHi;
    logic irq;
    logic level;
  } tgc_chan_t;

  tgc_chan_t chan_reg;
  tgc_chan_t chan_next;
  logic      hitLo;
  logic      hitHi;
  logic      anyPend;

  // ==========================================================
  // Next state
  always_comb begin
    chan_next = chan_reg;
    chan_next.irq = 1'b0;
    hitLo = matchLower & chan_reg.runLo;
    hitHi = matchUpper & chan_reg.runHi & splitMode;
    anyPend = chan_reg.pendLo | chan_reg.pendHi;
    // Stop waits for the timer clock edge
    if (stopLower && chan_reg.runLo) begin
      chan_next.stopLo = 1'b1;
    end
    if (stopUpper && splitMode && chan_reg.runHi) begin
      chan_next.stopHi = 1'b1;
    end
    if (timerTick && chan_next.stopLo) begin
      chan_next.runLo  = 1'b0;
      chan_next.stopLo = 1'b0;
    end
    if (timerTick && chan_next.stopHi) begin
      chan_next.runHi  = 1'b0;
      chan_next.stopHi = 1'b0;
    end
    // Start acts at once
    if (startLower) begin
      chan_next.runLo  = 1'b1;
      chan_next.stopLo = 1'b0;
    end
    if (startUpper && splitMode) begin
      chan_next.runHi  = 1'b1;
      chan_next.stopHi = 1'b0;
    end
    if (!splitMode) begin
      chan_next.runHi  = 1'b0;
      chan_next.stopHi = 1'b0;
    end
    // Output toggles on a lower-half match, rests at polarity level when idle
    if (!chan_next.runLo && !chan_next.runHi) begin
      chan_next.level = polarityNeg;
    end else if (hitLo) begin
      chan_next.level = ~chan_reg.level;
    end
    // Interrupt status: clear first so a same-cycle set wins
    if (splitMode) begin
      if (clearLower) begin
        chan_next.pendLo = 1'b0;
      end
      if (clearUpper) begin
        chan_next.pendHi = 1'b0;
      end
      if (hitLo) begin
        chan_next.pendLo = 1'b1;
      end
      if (hitHi) begin
        chan_next.pendHi = 1'b1;
      end
      chan_next.irq = (hitLo | hitHi) & ~anyPend;
      if (retrigger && (chan_next.pendLo || chan_next.pendHi)) begin
        chan_next.irq = 1'b1;
      end
    end else begin
      chan_next.pendLo = 1'b0;
      chan_next.pendHi = 1'b0;
      chan_next.irq    = hitLo;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      chan_reg <= '0;
    end else begin
      chan_reg <= chan_next;
    end
  end

  assign lowerRun     = chan_reg.runLo;
  assign upperRun     = chan_reg.runHi;
  assign lowerPending = chan_reg.pendLo;
  assign upperPending = chan_reg.pendHi;
  assign irqReq       = chan_reg.irq;
  assign outLevel     = chan_reg.level;
endmodule

/* File: rtl/tgc_timer_group.sv */
// Register front end and eight timer channels of the timer group control
`timescale 1ns/100ps
module tgc_timer_group (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [15:0] regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdata,
  input  wire logic [7:0]  timerTick,
  input  wire logic [7:0]  lowerMatch,
  input  wire logic [7:0]  upperMatch,
  output logic      [7:0]  lowerRun,
  output logic      [7:0]  upperRun,
  output logic      [7:0]  timerIrqReq,
  output logic      [7:0]  timerOutLevel,
  output logic      [7:0]  splitMode,
  output logic      [7:0]  clockSelect,
  output logic      [7:0]  oneShot,
  output logic             irqOut
);
  // ==========================================================
  // Address decode helper
  // True when the address falls in a per-timer bank of even words
  function automatic logic bankHit(input logic [15:0] addr,
                                   input logic [15:0] base);
    bankHit = (addr[15:4] == base[15:4]) && (addr[0] == 1'b0);
  endfunction

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0]      rdata;
    logic [7:0][15:0] mode;
    logic [7:0]       evtStatus;
    logic [7:0]       evtMask;
    logic             irq;
  } tgc_top_t;

  tgc_top_t top_reg;
  tgc_top_t top_next;

  logic [7:0] startLo;
  logic [7:0] startHi;
  logic [7:0] stopLo;
  logic [7:0] stopHi;
  logic [7:0] clrLo;
  logic [7:0] clrHi;
  logic [7:0] retrig;
  logic [7:0] pendLo;
  logic [7:0] pendHi;
  logic [7:0] chanIrq;
  logic [7:0] splitSel;
  logic [7:0] negSel;
  logic [2:0] bankIdx;
  logic       modeWr;
  logic       clrWr;

  // ==========================================================
  // Write strobes toward the channels
  always_comb begin
    bankIdx = regAddr[3:1];
    modeWr  = regWrite && bankHit(regAddr, tgc_pkg::MODE_BASE);
    clrWr   = regWrite && bankHit(regAddr, tgc_pkg::IRQ_CLR_BASE);
    startLo = tgc_pkg::BYTE_RESET;
    startHi = tgc_pkg::BYTE_RESET;
    stopLo  = tgc_pkg::BYTE_RESET;
    stopHi  = tgc_pkg::BYTE_RESET;
    clrLo   = tgc_pkg::BYTE_RESET;
    clrHi   = tgc_pkg::BYTE_RESET;
    retrig  = tgc_pkg::BYTE_RESET;
    // Whole bytes pass through so every set bit acts together
    if (regWrite && regAddr == tgc_pkg::START_OFFS) begin
      startLo = regWdata[7:0];
      startHi = regWdata[15:8];
    end
    if (regWrite && regAddr == tgc_pkg::STOP_OFFS) begin
      stopLo = regWdata[7:0];
      stopHi = regWdata[15:8];
    end
    if (clrWr) begin
      clrLo[bankIdx]  = regWdata[tgc_pkg::IC_LOWER_BIT];
      clrHi[bankIdx]  = regWdata[tgc_pkg::IC_UPPER_BIT];
      retrig[bankIdx] = regWdata[tgc_pkg::IC_RETRIG_BIT];
    end
  end

  // ==========================================================
  // Mode fields steering the channels
  always_comb begin
    for (int i = 0; i < tgc_pkg::NUM_TIMERS; i++) begin
      splitSel[i] = top_reg.mode[i][tgc_pkg::MODE_SPLIT_BIT];
      negSel[i]   = top_reg.mode[i][tgc_pkg::MODE_NEG_BIT];
    end
  end

  // ==========================================================
  // Timer channels
  generate
    for (genvar g = 0; g < tgc_pkg::NUM_TIMERS; g++) begin : gen_chan
      tgc_channel u_chan (
        .core_clk     (core_clk),
        .rst          (rst),
        .splitMode    (splitSel[g]),
        .polarityNeg  (negSel[g]),
        .timerTick    (timerTick[g]),
        .startLower   (startLo[g]),
        .startUpper   (startHi[g]),
        .stopLower    (stopLo[g]),
        .stopUpper    (stopHi[g]),
        .matchLower   (lowerMatch[g]),
        .matchUpper   (upperMatch[g]),
        .clearLower   (clrLo[g]),
        .clearUpper   (clrHi[g]),
        .retrigger    (retrig[g]),
        .lowerRun     (lowerRun[g]),
        .upperRun     (upperRun[g]),
        .lowerPending (pendLo[g]),
        .upperPending (pendHi[g]),
        .irqReq       (chanIrq[g]),
        .outLevel     (timerOutLevel[g])
      );
    end
  endgenerate

  // ==========================================================
  // Register file, read mux and interrupt collection
  always_comb begin
    top_next = top_reg;
    // Mode words keep only their writable bits
    if (modeWr) begin
      top_next.mode[bankIdx] = regWdata & tgc_pkg::MODE_WR_MASK;
    end
    if (regWrite && regAddr == tgc_pkg::EVT_MASK_OFFS) begin
      top_next.evtMask = regWdata[7:0];
    end
    // Read data stand one cycle after the read strobe
    top_next.rdata = tgc_pkg::READ_ZERO;
    if (regRead) begin
      if (regAddr == tgc_pkg::START_OFFS) begin
        top_next.rdata = tgc_pkg::READ_ZERO;
      end else if (regAddr == tgc_pkg::STOP_OFFS) begin
        top_next.rdata = tgc_pkg::READ_ZERO;
      end else if (regAddr == tgc_pkg::RUN_STAT_OFFS) begin
        top_next.rdata = {upperRun, lowerRun};
      end else if (regAddr == tgc_pkg::EVT_STAT_OFFS) begin
        top_next.rdata = {tgc_pkg::BYTE_RESET, top_reg.evtStatus};
      end else if (regAddr == tgc_pkg::EVT_MASK_OFFS) begin
        top_next.rdata = {tgc_pkg::BYTE_RESET, top_reg.evtMask};
      end else if (bankHit(regAddr, tgc_pkg::MODE_BASE)) begin
        top_next.rdata = top_reg.mode[bankIdx];
      end else if (bankHit(regAddr, tgc_pkg::IRQ_STAT_BASE)) begin
        top_next.rdata = {14'h0000, pendHi[bankIdx], pendLo[bankIdx]};
      end else begin
        top_next.rdata = tgc_pkg::READ_ZERO;
      end
    end
    // Sticky event bits: a read clears, a new request wins
    if (regRead && regAddr == tgc_pkg::EVT_STAT_OFFS) begin
      top_next.evtStatus = tgc_pkg::BYTE_RESET;
    end
    top_next.evtStatus = top_next.evtStatus | chanIrq;
    top_next.irq = |(top_next.evtStatus & top_next.evtMask);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      top_reg <= '0;
    end else begin
      top_reg <= top_next;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    for (int i = 0; i < tgc_pkg::NUM_TIMERS; i++) begin
      clockSelect[i] = top_reg.mode[i][tgc_pkg::MODE_CS_BIT];
      oneShot[i]     = top_reg.mode[i][tgc_pkg::MODE_OST_BIT];
    end
  end

  assign regRdata    = top_reg.rdata;
  assign splitMode   = splitSel;
  assign timerIrqReq = chanIrq;
  assign irqOut      = top_reg.irq;
endmodule

/* File: verif/tgc_timer_group_chk.sv */
// Concurrent checks on the timer group control ports
`timescale 1ns/100ps
module tgc_timer_group_chk (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdata,
  input wire logic [7:0]  lowerMatch,
  input wire logic [7:0]  lowerRun,
  input wire logic [7:0]  upperRun,
  input wire logic [7:0]  timerIrqReq,
  input wire logic [7:0]  splitMode
);
  // ==========================================================
  // Helpers
  logic [15:0] stopMask_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Bits of the last stop write
  always_ff @(posedge core_clk) begin
    if (regWrite && regAddr == 16'hf352) begin
      stopMask_reg <= regWdata;
    end
  end
  sequence startWr;
    regWrite && regAddr == 16'hf350;
  endsequence
  sequence stopWr;
    regWrite && regAddr == 16'hf352;
  endsequence
  // ==========================================================
  // Assertions
  a_start_lower: assert property (
    startWr |=> (~lowerRun & $past(regWdata[7:0])) == 8'h00)
    else $error("start write left a lower half stopped");
  a_start_upper: assert property (
    startWr |=> (~upperRun & $past(regWdata[15:8]) & $past(splitMode))
    == 8'h00) else $error("start write left an upper half stopped");
  a_upper_ignored: assert property (
    (upperRun & ~$past(upperRun) & ~$past(splitMode)) == 8'h00)
    else $error("upper half started outside split mode");
  a_stop_lower: assert property (
    stopWr |-> ##[1:6] ((lowerRun & stopMask_reg[7:0]) == 8'h00))
    else $error("stop write did not stop a lower half");
  a_stop_upper: assert property (
    stopWr |-> ##[1:6] ((upperRun & stopMask_reg[15:8]) == 8'h00))
    else $error("stop write did not stop an upper half");
  a_ctrl_reads_zero: assert property (
    regRead && (regAddr == 16'hf350 || regAddr == 16'hf352 ||
    regAddr[15:4] == 12'hf34) |=> regRdata == 16'h0000)
    else $error("write-only register read nonzero");
  a_run_status: assert property (
    regRead && regAddr == 16'hf354 |=>
    regRdata == {$past(upperRun), $past(lowerRun)})
    else $error("run status read wrong");
  a_match_req: assert property (
    (lowerMatch & lowerRun & ~splitMode) != 8'h00 |=>
    (~timerIrqReq & $past(lowerMatch) & $past(lowerRun) &
    ~$past(splitMode)) == 8'h00)
    else $error("16-bit match gave no request");
endmodule

bind tgc_timer_group tgc_timer_group_chk i_chk (
  .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .lowerMatch(lowerMatch), .lowerRun(lowerRun),
  .upperRun(upperRun), .timerIrqReq(timerIrqReq), .splitMode(splitMode)
);

/* File: verif/tb.sv */
// Self-checking bench for the timer group control block
`timescale 1ns/100ps
module tb;
  // ==========================================================
  // Signals
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [15:0] regWdata = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [15:0] regRdata;
  logic [7:0]  timerTick = 8'h00;
  logic [7:0]  lowerMatch = 8'h00;
  logic [7:0]  upperMatch = 8'h00;
  logic [7:0]  lowerRun, upperRun, timerIrqReq, splitMode;
  logic        irqOut;
  logic [7:0]  outLevel, clkSel, oneShotSel;
  logic [1:0]  tickCnt = 2'b00;
  int          reqCnt = 0;
  int          cycles = 0;
  int          err_total = 0;
  int          checked = 0;

  tgc_timer_group i_dut (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .timerTick(timerTick),
    .lowerMatch(lowerMatch), .upperMatch(upperMatch),
    .lowerRun(lowerRun), .upperRun(upperRun),
    .timerIrqReq(timerIrqReq), .timerOutLevel(outLevel),
    .splitMode(splitMode), .clockSelect(clkSel), .oneShot(oneShotSel),
    .irqOut(irqOut)
  );

  // ==========================================================
  // Clock, timer tick every fourth cycle, request count, timeout
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    tickCnt <= tickCnt + 2'd1;
    timerTick <= (tickCnt == 2'd0) ? 8'hff : 8'h00;
    if (timerIrqReq[4] === 1'b1) reqCnt <= reqCnt + 1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      end_sim();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), regRdata, exp);
  endtask
  task automatic pm(input logic [7:0] lo, input logic [7:0] up);
    @(posedge core_clk);
    lowerMatch <= lo;
    upperMatch <= up;
    @(posedge core_clk);
    lowerMatch <= 8'h00;
    upperMatch <= 8'h00;
    idle(3);
  endtask
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(16'hf354, 16'h0000);
    rd(16'hf350, 16'h0000);
    rd(16'hf352, 16'h0000);
    rd(16'hf3fe, 16'h0000);
    $display("Test reset done");
    wr(16'hf350, 16'hffff);
    rd(16'hf354, 16'h00ff);
    pm(8'h01, 8'h00);
    chk("out level", {8'h00, outLevel}, 16'h0001);
    wr(16'hf352, 16'hff00);
    idle(6);
    rd(16'hf354, 16'h00ff);
    wr(16'hf352, 16'h0055);
    idle(6);
    rd(16'hf354, 16'h00aa);
    wr(16'hf352, 16'h00aa);
    idle(6);
    rd(16'hf354, 16'h0000);
    chk("out level", {8'h00, outLevel}, 16'h0000);
    $display("Test whole timers done");
    for (int n = 0; n < 8; n++) begin
      wr(16'hf320 + 16'(2 * n), 16'h0100);
    end
    wr(16'hf350, 16'hffff);
    rd(16'hf354, 16'hffff);
    wr(16'hf352, 16'h0f00);
    idle(6);
    rd(16'hf354, 16'hf0ff);
    $display("Test split halves done");
    pm(8'h10, 8'h00);
    chk("request count", 16'(reqCnt), 16'h0001);
    chk("masked irq", {15'h0000, irqOut}, 16'h0000);
    wr(16'hf362, 16'h0010);
    idle(2);
    chk("unmasked irq", {15'h0000, irqOut}, 16'h0001);
    rd(16'hf360, 16'h0011);
    idle(2);
    chk("cleared irq", {15'h0000, irqOut}, 16'h0000);
    rd(16'hf338, 16'h0001);
    pm(8'h00, 8'h10);
    rd(16'hf338, 16'h0003);
    chk("request count", 16'(reqCnt), 16'h0001);
    wr(16'hf348, 16'h0001);
    rd(16'hf338, 16'h0002);
    wr(16'hf348, 16'h0080);
    idle(3);
    chk("request count", 16'(reqCnt), 16'h0002);
    chk("retrigger irq", {15'h0000, irqOut}, 16'h0001);
    wr(16'hf348, 16'h0002);
    rd(16'hf338, 16'h0000);
    rd(16'hf348, 16'h0000);
    wr(16'hf348, 16'h0080);
    idle(3);
    chk("request count", 16'(reqCnt), 16'h0002);
    $display("Test interrupt clear done");
    wr(16'hf352, 16'hf0ff);
    idle(6);
    rd(16'hf354, 16'h0000);
    wr(16'hf324, 16'h0600);
    idle(2);
    chk("out level", {8'h00, outLevel}, 16'h0004);
    wr(16'hf350, 16'h0004);
    pm(8'h04, 8'h00);
    chk("out level", {8'h00, outLevel}, 16'h0000);
    wr(16'hf352, 16'h0004);
    wr(16'hf324, 16'h0601);
    idle(1);
    chk("clock select", {clkSel, oneShotSel}, 16'h0404);
    wr(16'hf324, 16'h0600);
    idle(4);
    chk("clock select", {clkSel, oneShotSel}, 16'h0004);
    rd(16'hf354, 16'h0000);
    chk("out level", {8'h00, outLevel}, 16'h0004);
    $display("Test output level done");
    end_sim();
  end
endmodule
